// ==== ptp_pkg.sv ====
// Package with register map, field layouts and carrier types for the pipeline.
package ptp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_GENERAL_CONFIG = 7'h00;
    localparam logic [6:0] ADDR_START_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_GEAR_FACTOR = 7'h12;
    localparam logic [6:0] ADDR_WRITEBACK_SELECT = 7'h33;
    localparam logic [6:0] ADDR_POSITION_COMPARE = 7'h32;
    localparam logic [6:0] ADDR_TARGET_POSITION = 7'h37;
    localparam logic [6:0] ADDR_STAGE_FIRST = 7'h38;
    localparam logic [6:0] ADDR_STAGE_LAST = 7'h3f;

    // ------------------------------------------------------------------
    // Sizes, field positions and reset values
    // ------------------------------------------------------------------
    localparam int NUM_STAGES = 8;
    localparam int NUM_DEST = 4;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 3;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [2:0] STAGE_NONE = 3'h0;

    // Destination indices, ascending bit order of the select field.
    localparam int DEST_TARGET = 0;
    localparam int DEST_COMPARE = 1;
    localparam int DEST_GEAR = 2;
    localparam int DEST_CONFIG = 3;

    // Serial register port request, already in the system clock domain.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [31:0] wdata;
    } ptp_req_t;

    // Per destination: is it fed, and from which stage.
    typedef struct packed {
        logic en;
        logic [2:0] head;
    } ptp_map_t;

endpackage

// ==== ptp_mapper.sv ====
// Segment mapper: turns the four-bit select field into heads and segment ends.
`timescale 1ns/1ps
module ptp_mapper (
    input wire logic [3:0] i_sel,
    output ptp_pkg::ptp_map_t [3:0] o_map,
    output logic [7:0] o_seg_end
);

    // ------------------------------------------------------------------
    // Head lookup
    // ------------------------------------------------------------------
    // Head stage of the k-th active segment given the number of segments.
    function automatic logic [2:0] head_of(input logic [2:0] cnt,
                                           input logic [2:0] k);
        logic [2:0] h;
        h = ptp_pkg::STAGE_NONE;
        case (cnt)
            3'h2: h = (k == 3'h1) ? 3'h4 : 3'h0;
            3'h3: h = (k == 3'h2) ? 3'h6 : ((k == 3'h1) ? 3'h3 : 3'h0);
            3'h4: h = 3'(k << 1);
            default: h = ptp_pkg::STAGE_NONE;
        endcase
        return h;
    endfunction

    // ------------------------------------------------------------------
    // Mapping
    // ------------------------------------------------------------------
    // Count set bits, rank each enabled destination, mark segment tops.
    always_comb begin
        logic [2:0] cnt;
        logic [2:0] rank;
        cnt = 3'h0;
        rank = 3'h0;
        o_seg_end = 8'h00;
        for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
            cnt = cnt + {2'h0, i_sel[d]};
        end
        for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
            o_map[d].en = i_sel[d];
            o_map[d].head = i_sel[d] ? head_of(cnt, rank) : 3'h0;
            if (i_sel[d]) begin
                rank = rank + 3'h1;
            end
        end
        // A segment ends below the next head, and stage 7 always ends one.
        o_seg_end[7] = 1'b1;
        for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
            if (i_sel[d] && o_map[d].head != 3'h0) begin
                o_seg_end[3'(o_map[d].head - 3'h1)] = 1'b1;
            end
        end
    end

endmodule // ptp_mapper

// ==== ptp_pipeline.sv ====
// Eight-stage parameter pipeline feeding four destination registers.
`timescale 1ns/1ps
module ptp_pipeline (
    input wire logic i_clk,
    input wire logic i_nrst,
    input ptp_pkg::ptp_req_t i_req,
    input wire logic i_start,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic [31:0] o_target_position,
    output logic [31:0] o_position_compare,
    output logic [31:0] o_gear_factor,
    output logic [31:0] o_general_config
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] stage [ptp_pkg::NUM_STAGES];
    logic [31:0] next_stage [ptp_pkg::NUM_STAGES];
    logic [31:0] dest [ptp_pkg::NUM_DEST];
    logic [31:0] next_dest [ptp_pkg::NUM_DEST];
    logic [31:0] start_config;
    logic [31:0] next_start_config;
    logic [7:0] writeback_select;
    logic [7:0] next_writeback_select;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    ptp_pkg::ptp_map_t [3:0] map;
    logic [7:0] seg_end;
    logic [3:0] sel;
    logic transfer;

    // Destination index for a register address, or -1 when not one.
    function automatic int dest_of(input logic [6:0] a);
        int d;
        case (a)
            ptp_pkg::ADDR_TARGET_POSITION: d = ptp_pkg::DEST_TARGET;
            ptp_pkg::ADDR_POSITION_COMPARE: d = ptp_pkg::DEST_COMPARE;
            ptp_pkg::ADDR_GEAR_FACTOR: d = ptp_pkg::DEST_GEAR;
            ptp_pkg::ADDR_GENERAL_CONFIG: d = ptp_pkg::DEST_CONFIG;
            default: d = -1;
        endcase
        return d;
    endfunction

    // True when the address lies in the stage window.
    function automatic logic is_stage(input logic [6:0] a);
        return (a >= ptp_pkg::ADDR_STAGE_FIRST) &&
               (a <= ptp_pkg::ADDR_STAGE_LAST);
    endfunction

    assign sel = start_config[ptp_pkg::SEL_MSB:ptp_pkg::SEL_LSB];
    // No enabled destination means start pulses move nothing.
    assign transfer = i_start && (sel != ptp_pkg::SEL_NONE);

    // ------------------------------------------------------------------
    // Segment mapping
    // ------------------------------------------------------------------
    ptp_mapper u_mapper (
        .i_sel(sel),
        .o_map(map),
        .o_seg_end(seg_end)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // A transfer and a host write in the same cycle: the host write lands
    // last, so freshly written values are never lost to a shift.
    always_comb begin
        int wd;
        int si;
        wd = dest_of(i_req.addr);
        si = int'(i_req.addr - ptp_pkg::ADDR_STAGE_FIRST);
        next_start_config = start_config;
        next_writeback_select = writeback_select;
        for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
            next_stage[s] = stage[s];
        end
        for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
            next_dest[d] = dest[d];
        end
        if (transfer) begin
            // Each enabled destination takes its segment head.
            for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
                if (map[d].en) begin
                    next_dest[d] = stage[map[d].head];
                end
            end
            // Simultaneous shift toward the head inside each segment.
            for (int s = 0; s < ptp_pkg::NUM_STAGES - 1; s++) begin
                if (!seg_end[s]) begin
                    next_stage[s] = stage[s + 1];
                end
            end
            // Cyclic write-back of the current target value.
            for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
                if (writeback_select[s]) begin
                    next_stage[s] = dest[ptp_pkg::DEST_TARGET];
                end
            end
        end
        if (i_req.wr) begin
            if (wd >= 0) begin
                next_dest[wd] = i_req.wdata;
            end else if (is_stage(i_req.addr)) begin
                next_stage[si] = i_req.wdata;
            end else if (i_req.addr == ptp_pkg::ADDR_START_CONFIG) begin
                next_start_config = i_req.wdata;
            end else if (i_req.addr == ptp_pkg::ADDR_WRITEBACK_SELECT) begin
                next_writeback_select = i_req.wdata[7:0];
            end
        end
    end

    // Read path; unmapped addresses read as zero.
    always_comb begin
        int rd;
        int ri;
        rd = dest_of(i_req.addr);
        ri = int'(i_req.addr - ptp_pkg::ADDR_STAGE_FIRST);
        next_rvalid = i_req.rd;
        next_rdata = ptp_pkg::RESET_VALUE;
        if (i_req.rd) begin
            if (rd >= 0) begin
                next_rdata = dest[rd];
            end else if (is_stage(i_req.addr)) begin
                next_rdata = stage[ri];
            end else if (i_req.addr == ptp_pkg::ADDR_START_CONFIG) begin
                next_rdata = start_config;
            end else if (i_req.addr == ptp_pkg::ADDR_WRITEBACK_SELECT) begin
                next_rdata = {24'h000000, writeback_select};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // All state resets to zero: the pipeline starts disabled.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
                stage[s] <= ptp_pkg::RESET_VALUE;
            end
            for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
                dest[d] <= ptp_pkg::RESET_VALUE;
            end
            start_config <= ptp_pkg::RESET_VALUE;
            writeback_select <= 8'h00;
            rdata <= ptp_pkg::RESET_VALUE;
            rvalid <= 1'b0;
        end else begin
            for (int s = 0; s < ptp_pkg::NUM_STAGES; s++) begin
                stage[s] <= next_stage[s];
            end
            for (int d = 0; d < ptp_pkg::NUM_DEST; d++) begin
                dest[d] <= next_dest[d];
            end
            start_config <= next_start_config;
            writeback_select <= next_writeback_select;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Destination values come straight from their flip-flops.
    assign o_target_position = dest[ptp_pkg::DEST_TARGET];
    assign o_position_compare = dest[ptp_pkg::DEST_COMPARE];
    assign o_gear_factor = dest[ptp_pkg::DEST_GEAR];
    assign o_general_config = dest[ptp_pkg::DEST_CONFIG];
    assign o_rdata = rdata;
    assign o_rvalid = rvalid;

endmodule // ptp_pipeline

// ==== ptp_pipeline_checker.sv ====
// Concurrent assertions on the ports of the parameter pipeline.
`timescale 1ns/1ps
module ptp_pipeline_checker (
    input wire logic i_clk,
    input wire logic i_nrst,
    input ptp_pkg::ptp_req_t i_req,
    input wire logic i_start,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [31:0] o_target_position,
    input wire logic [31:0] o_position_compare,
    input wire logic [31:0] o_gear_factor,
    input wire logic [31:0] o_general_config
);
    logic [3:0] sel;
    logic [3:0] next_sel;

    // ----------------------------------------------------------------
    // Select field shadow
    // ----------------------------------------------------------------
    // The field sits inside the block, so it is rebuilt from the writes.
    always_comb begin
        next_sel = sel;
        if (i_req.wr && i_req.addr == ptp_pkg::ADDR_START_CONFIG) begin
            next_sel = i_req.wdata[3:0];
        end
    end

    // Registers the shadow; cleared with the block.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel <= ptp_pkg::SEL_NONE;
        end else begin
            sel <= next_sel;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    read_answer_a: assert property (i_req.rd |=> o_rvalid)
        else $error("Read strobe got no answer.");
    rvalid_cause_a: assert property (o_rvalid |-> $past(i_req.rd))
        else $error("Read answer without a read strobe.");
    rdata_idle_a: assert property (!o_rvalid |-> o_rdata == 32'h0)
        else $error("Read data not zero while idle.");
    target_write_a: assert property (i_req.wr
        && i_req.addr == ptp_pkg::ADDR_TARGET_POSITION
        |=> o_target_position == $past(i_req.wdata))
        else $error("Target position write lost.");
    gear_write_a: assert property (i_req.wr
        && i_req.addr == ptp_pkg::ADDR_GEAR_FACTOR
        |=> o_gear_factor == $past(i_req.wdata))
        else $error("Gear factor write lost.");
    idle_hold_a: assert property (!i_start && !i_req.wr
        |=> $stable(o_target_position) && $stable(o_general_config))
        else $error("Destination moved without start or write.");
    no_move_a: assert property (i_start && sel == 4'h0 && !i_req.wr
        |=> $stable({o_target_position, o_position_compare,
        o_gear_factor, o_general_config}))
        else $error("Start moved a destination with no pipeline on.");
    compare_off_a: assert property (i_start && !sel[1] && !i_req.wr
        |=> $stable(o_position_compare))
        else $error("Disabled compare destination was fed.");
endmodule // ptp_pipeline_checker

bind ptp_pipeline ptp_pipeline_checker i_chk (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_req(i_req), .i_start(i_start),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_target_position(o_target_position),
    .o_position_compare(o_position_compare),
    .o_gear_factor(o_gear_factor), .o_general_config(o_general_config));

// ==== tb.sv ====
// Self-checking testbench for the parameter pipeline.
`timescale 1ns/1ps
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    ptp_pkg::ptp_req_t i_req = '0;
    logic i_start = 1'b0;
    logic [31:0] o_rdata;
    logic o_rvalid;
    logic [31:0] dout [4];
    logic [31:0] stg [8];
    logic [31:0] dst [4];
    logic [7:0] wb;
    logic [6:0] da [4] = '{ptp_pkg::ADDR_TARGET_POSITION,
        ptp_pkg::ADDR_POSITION_COMPARE, ptp_pkg::ADDR_GEAR_FACTOR,
        ptp_pkg::ADDR_GENERAL_CONFIG};
    // Head stage of each segment, by number of segments.
    int hd [5][4] = '{'{0, 0, 0, 0}, '{0, 0, 0, 0}, '{0, 4, 0, 0},
        '{0, 3, 6, 0}, '{0, 2, 4, 6}};
    int mismatches = 0;
    int n_checks = 0;

    ptp_pipeline i_ptp_pipeline (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_req(i_req), .i_start(i_start), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_target_position(dout[0]),
        .o_position_compare(dout[1]), .o_gear_factor(dout[2]),
        .o_general_config(dout[3]));

    // 40 MHz clock.
    always #12.5 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Compares with case equality, so an unknown never matches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // One-cycle write strobe; the expected image follows the write.
    task automatic put(input logic [6:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_req.wr <= 1'b1;
        i_req.addr <= a;
        i_req.wdata <= d;
        @(posedge i_clk);
        i_req.wr <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (a == 7'(ptp_pkg::ADDR_STAGE_FIRST + i)) stg[i] = d;
        end
        for (int i = 0; i < 4; i++) begin
            if (a == da[i]) dst[i] = d;
        end
    endtask

    // The answer stands for one cycle only, so it is sampled just then.
    task automatic get(input logic [6:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_req.rd <= 1'b1;
        i_req.addr <= a;
        @(posedge i_clk);
        i_req.rd <= 1'b0;
        #1;
        chk({31'h0, o_rvalid}, 32'h1);
        chk(o_rdata, e);
    endtask

    // Reference transfer: shift within segments, write back, feed heads.
    task automatic step(input logic [3:0] s);
        logic [31:0] o [8];
        int c;
        int k;
        logic top;
        o = stg;
        c = $countones(s);
        k = 0;
        if (c == 0) return;
        for (int n = 0; n < 8; n++) begin
            top = (n == 7);
            for (int j = 1; j < c; j++) top |= (hd[c][j] == n + 1);
            if (!top) stg[n] = o[n + 1];
            if (wb[n]) stg[n] = dst[0];
        end
        for (int d = 0; d < 4; d++) begin
            if (s[d]) begin
                dst[d] = o[hd[c][k]];
                k++;
            end
        end
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    // Every select code, two back-to-back starts each.
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        get(ptp_pkg::ADDR_STAGE_LAST, 32'h0);
        get(7'h7f, 32'h0);
        for (int s = 0; s < 16; s++) begin
            wb = s[0] ? 8'h10 : 8'h80;
            for (int i = 0; i < 8; i++) begin
                put(7'(ptp_pkg::ADDR_STAGE_FIRST + i), {4'h1, 20'(s), 8'(i)});
            end
            for (int d = 0; d < 4; d++) put(da[d], {4'h2, 20'(s), 8'(d)});
            put(ptp_pkg::ADDR_WRITEBACK_SELECT, {24'h0, wb});
            put(ptp_pkg::ADDR_START_CONFIG, {28'h0, 4'(s)});
            get(ptp_pkg::ADDR_START_CONFIG, {28'h0, 4'(s)});
            @(posedge i_clk);
            i_start <= 1'b1;
            repeat (2) @(posedge i_clk);
            i_start <= 1'b0;
            step(4'(s));
            step(4'(s));
            // Compare is reloaded right after the start, as software would.
            put(ptp_pkg::ADDR_POSITION_COMPARE, {4'h3, 20'(s), 8'h00});
            #1;
            for (int d = 0; d < 4; d++) chk(dout[d], dst[d]);
            for (int i = 0; i < 8; i++) begin
                get(7'(ptp_pkg::ADDR_STAGE_FIRST + i), stg[i]);
            end
            $display("Test select %h writeback %h done", s[3:0], wb);
        end
        results();
    end

    // The tests need about 830 cycles; a hang is cut well after that.
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        results();
    end
endmodule // tb
